/* dv/gpa_pins.sv */
// board circuitry model on the three port pins
`timescale 1ns/1ps
module gpa_pins (
  input  logic                 core_clk, // system clock, paces the floating pattern
  input  gpa_pkg::gpa_pad_type pad,      // pad controls of the port
  input  logic [2:0]           ext_drv,  // level the board forces
  input  logic [2:0]           ext_en,   // board drives the pin
  output logic [2:0]           level     // resolved pin level
);
  import gpa_pkg::*;
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  logic [2:0] float_q = 3'h0;
  // an undriven line wanders, so a stale level can never pass for a real one
  always @(posedge core_clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad.oe[i]) level[i] = pad.out[i];
      else if (ext_en[i]) level[i] = ext_drv[i];
      else if (pad.pull_up[i]) level[i] = 1'b1;
      else if (pad.pull_dn[i]) level[i] = 1'b0;
      else level[i] = float_q[i];
    end
  end
endmodule

/* dv/test_gpa_port.sv */
// self-checking bench of the three-pin port over its register bus
`timescale 1ns/1ps
module test_gpa_port;
  import gpa_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, eclk, irq;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pin, ext_irq, ext_drv, ext_en;
  gpa_pad_type pad_o;
  gpa_alt_type alt;
  int          miscompares, checked;
  localparam logic [5:0] SEL [4] = '{6'h00, 6'h20, 6'h14, 6'h0B};
  localparam logic [2:0] EX [4]  = '{3'h0, 3'h1, 3'h3, 3'h7};
  gpa_port u_gpa_port (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pin_level(pin), .pad_ctl(pad_o), .alt_func(alt), .ext_irq_in(ext_irq), .external_clock_in(eclk), .irq(irq));
  gpa_pins u_gpa_pins (.core_clk(core_clk), .pad(pad_o), .ext_drv(ext_drv), .ext_en(ext_en), .level(pin));
  always #12.5 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // bready and rready stay high all run, so a response is never left waiting
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s = 4'h1,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    awaddr <= {idx, 2'h0};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (++n > 50) begin
        miscompares++;
        conclude();
      end
    end while (bvalid !== 1'b1);
    chk("bresp", bresp, er);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (++n > 50) begin
        miscompares++;
        conclude();
      end
    end while (rvalid !== 1'b1);
    chk("rdata", rdata, e);
    chk("rresp", rresp, er);
  endtask
  function automatic logic [31:0] pair(input logic [1:0] c);
    return {21'h0, {3{c[1]}}, 5'h0, {3{c[0]}}};
  endfunction
  function automatic logic [2:0] oe_exp(input logic [1:0] c, input logic [2:0] d);
    case (c)
      CFG_PCH: return d;
      CFG_NCH: return ~d;
      CFG_CMOS: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] m, oe;
    logic [1:0] cw;
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata, wstrb} = '0;
    alt = '0;
    ext_drv = 3'h0;
    ext_en = 3'h7;
    miscompares = 0;
    checked = 0;
    tick(4);
    sys_rst <= 1'b0;
    tick(1);
    chk("pad", pad_o, RST_PAD);
    for (int i = 0; i < 6; i++) rdc(IDX_LEVEL + 16'(i), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_DIR + 16'(2 * i), 32'hFFFFFFFF, 4'hF);
      rdc(IDX_DIR + 16'(2 * i), 32'h7);
      wr(IDX_DIR + 16'(2 * i), 32'h0);
    end
    wr(IDX_DIR, 32'h7, 4'h0);
    rdc(IDX_DIR, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_CFG_LO + 16'(2 * i), 32'h0605, 4'h3);
      rdc(IDX_CFG_HI + 16'(2 * i), 32'h6);
      rdc(IDX_CFG_LO + 16'(2 * i), 32'h0605);
      wr(IDX_CFG_LO + 16'(2 * i), 32'h0, 4'h3);
    end
    // second pass puts pins 1 and 2 on their missing secondary function
    wr(IDX_LEVEL, 32'h5);
    for (int p = 0; p < 2; p++) begin
      m = p ? 3'h1 : 3'h7;
      wr(IDX_FSEL_LO, {29'h0, ~m});
      for (int c = 0; c < 4; c++) begin
        cw = 2'(c);
        wr(IDX_CFG_LO, pair(cw), 4'h3);
        tick(2);
        oe = (oe_exp(cw, 3'h5) & m) | ({3{cw[1]}} & ~m);
        chk("oe", pad_o.oe, oe);
        chk("out", pad_o.out & oe, 3'h5 & oe & m);
      end
    end
    wr(IDX_LEVEL, 32'h0);
    wr(IDX_CFG_LO, pair(CFG_CMOS), 4'h3);
    for (int f = 1; f < 4; f++) begin
      wr(IDX_FSEL_LO, pair(2'(f)), 4'h3);
      for (int k = 0; k < 2; k++) begin
        alt <= gpa_alt_type'(k ? ~SEL[f] : SEL[f]);
        tick(2);
        chk("alt", pad_o.out, k ? 3'h0 : EX[f]);
      end
    end
    wr(IDX_FSEL_LO, pair(FSEL_TER), 4'h3);
    wr(IDX_DIR, 32'h4);
    ext_drv <= 3'h4;
    tick(8);
    chk("external_clock_in", eclk, 1'b1);
    wr(IDX_FSEL_LO, 32'h0, 4'h3);
    tick(2);
    chk("external_clock_in", eclk, 1'b0);
    wr(IDX_DIR, 32'h7);
    for (int c = 0; c < 4; c++) begin
      cw = 2'(c);
      wr(IDX_CFG_LO, pair(cw), 4'h3);
      tick(2);
      chk("pulls", pad_o, {3'h0, 3'h0, {3{cw == CFG_NCH}}, {3{cw == CFG_PCH}}});
    end
    wr(IDX_CFG_LO, pair(CFG_NCH), 4'h3);
    ext_en <= 3'h0;
    tick(8);
    rdc(IDX_LEVEL, 32'h7);
    ext_en <= 3'h7;
    ext_drv <= 3'h2;
    wr(IDX_DIR, 32'h3);
    wr(IDX_LEVEL, 32'h4);
    tick(8);
    rdc(IDX_LEVEL, 32'h6);
    chk("exti", ext_irq, 3'h2);
    wr(IDX_DIR, 32'h7);
    wr(IDX_IRQ_STAT, 32'h7);
    rdc(IDX_IRQ_STAT, 32'h0);
    ext_drv <= 3'h3;
    tick(8);
    chk("exti", ext_irq, 3'h3);
    rdc(IDX_IRQ_STAT, 32'h1);
    chk("irq", irq, 1'b0);
    wr(IDX_IRQ_MASK, 32'h1);
    tick(2);
    chk("irq", irq, 1'b1);
    wr(IDX_IRQ_STAT, 32'h1);
    tick(2);
    chk("irq", irq, 1'b0);
    rdc(IDX_IRQ_STAT, 32'h0);
    // all three pins parked as hiz outputs while the board feeds them analog levels
    wr(IDX_DIR, 32'h0);
    wr(IDX_CFG_LO, 32'h0, 4'h3);
    tick(2);
    chk("analog", pad_o, RST_PAD);
    wr(16'hF258, 32'h7, 4'h1, RESP_SLVERR);
    rdc(16'hF258, 32'h0, RESP_SLVERR);
    conclude();
  end
endmodule

/* inc/gpa_pkg.sv */
// package: register map, codes and carriers of the three-pin general-purpose port
package gpa_pkg;

  // ----------------------------------------------------------------
  // sizes and register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned NPIN         = 3;
  localparam logic [15:0] IDX_LEVEL    = 16'hF250;
  localparam logic [15:0] IDX_DIR      = 16'hF251;
  localparam logic [15:0] IDX_CFG_LO   = 16'hF252;
  localparam logic [15:0] IDX_CFG_HI   = 16'hF253;
  localparam logic [15:0] IDX_FSEL_LO  = 16'hF254;
  localparam logic [15:0] IDX_FSEL_HI  = 16'hF255;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hF256;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hF257;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PAIR_LSB  = 8;
  localparam logic [2:0]  RST_PORT  = 3'h0;
  localparam logic        DIR_OUT   = 1'b0;

  // ----------------------------------------------------------------
  // drive and function codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_HIZ     = 2'h0;
  localparam logic [1:0] CFG_PCH     = 2'h1;
  localparam logic [1:0] CFG_NCH     = 2'h2;
  localparam logic [1:0] CFG_CMOS    = 2'h3;
  localparam logic [1:0] FSEL_GPIO   = 2'h0;
  localparam logic [1:0] FSEL_SEC    = 2'h1;
  localparam logic [1:0] FSEL_TER    = 2'h2;
  localparam logic [1:0] FSEL_FOURTH = 2'h3;
  // pins that own a secondary function
  localparam logic [2:0] FSEL_SEC_OK = 3'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
    logic [2:0] pull_up;
    logic [2:0] pull_dn;
  } gpa_pad_type;

  typedef struct packed {
    logic [2:0] level;
    logic [2:0] dir;
    logic [2:0] cfg_lo;
    logic [2:0] cfg_hi;
    logic [2:0] fsel_lo;
    logic [2:0] fsel_hi;
  } gpa_regs_type;

  typedef struct packed {
    logic pwm;
    logic fast_clk;
    logic timer9;
    logic slow_clk;
    logic timer_f;
    logic cmp0;
  } gpa_alt_type;

  localparam gpa_regs_type RST_REGS = '0;
  localparam gpa_pad_type  RST_PAD  = '0;

endpackage

/* src/gpa_drive.sv */
// per-pin drive, pull and function multiplexing of the port
`timescale 1ns/1ps
module gpa_drive (
  input  gpa_pkg::gpa_regs_type regs, // port registers
  input  gpa_pkg::gpa_alt_type  alt,  // peripheral outputs
  output gpa_pkg::gpa_pad_type  pad   // pad controls
);
  import gpa_pkg::*;

  function automatic logic alt_value(input int unsigned pin, input logic [1:0] fsel,
                                     input logic dat, input gpa_alt_type a);
    logic v;
    v = dat;
    if (pin == 0) begin
      if (fsel == FSEL_SEC) v = a.pwm;
      else if (fsel == FSEL_TER) v = a.fast_clk;
      else if (fsel == FSEL_FOURTH) v = a.timer9;
    end else if (pin == 1) begin
      if (fsel == FSEL_TER) v = a.slow_clk;
      else if (fsel == FSEL_FOURTH) v = a.timer_f;
    end else begin
      if (fsel == FSEL_FOURTH) v = a.cmp0;
    end
    return v;
  endfunction

  logic [1:0] cfg;
  logic [1:0] fsel;
  logic       v;

  // each pin decoded from its own bit of every register
  always_comb begin
    pad  = RST_PAD;
    cfg  = CFG_HIZ;
    fsel = FSEL_GPIO;
    v    = 1'b0;
    for (int unsigned i = 0; i < NPIN; i++) begin
      cfg  = {regs.cfg_hi[i], regs.cfg_lo[i]};
      fsel = {regs.fsel_hi[i], regs.fsel_lo[i]};
      v    = alt_value(i, fsel, regs.level[i], alt);
      if (regs.dir[i] == DIR_OUT) begin
        if (fsel == FSEL_SEC && !FSEL_SEC_OK[i]) begin
          // data ignored: low in the n-channel and cmos modes
          pad.oe[i]  = cfg[1];
          pad.out[i] = 1'b0;
        end else begin
          case (cfg)
            CFG_PCH: begin
              pad.oe[i]  = v;
              pad.out[i] = 1'b1;
            end
            CFG_NCH: begin
              pad.oe[i]  = !v;
              pad.out[i] = 1'b0;
            end
            CFG_CMOS: begin
              pad.oe[i]  = 1'b1;
              pad.out[i] = v;
            end
            default: begin
              pad.oe[i]  = 1'b0;
              pad.out[i] = 1'b0;
            end
          endcase
        end
      end else begin
        pad.pull_dn[i] = (cfg == CFG_PCH);
        pad.pull_up[i] = (cfg == CFG_NCH);
      end
    end
  end
endmodule

/* src/gpa_port.sv */
// three-pin general-purpose port with axi4-lite registers and pin-change interrupt
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - three pins, each set by own bits
// - output mode drives data bit level
// - read gives pin if input, data if output
// - direction 0 output, 1 input; resets 0
// - output drive: hiz, p-drain, n-drain, cmos
// - input: hiz, pull-down, pull-up, hiz
// - reset leaves every pin hiz output
// - six byte registers, read-write, reset zero
// - cfg and fsel low take 16-bit access
// - alternate outputs and clock input per pin
// - every pin also feeds external interrupt
// - function pair selects gpio or alternates
// - prohibited selection ignores data bit
module gpa_port #(
  parameter int unsigned ADDR_W = 18
) (
  input  logic                 core_clk,          // system clock
  input  logic                 sys_rst,           // synchronous reset, active high
  input  logic                 s_axi_awvalid,     // write address valid
  output logic                 s_axi_awready,     // write address ready
  input  logic [ADDR_W-1:0]    s_axi_awaddr,      // write byte address
  input  logic                 s_axi_wvalid,      // write data valid
  output logic                 s_axi_wready,      // write data ready
  input  logic [31:0]          s_axi_wdata,       // write data
  input  logic [3:0]           s_axi_wstrb,       // byte strobes
  output logic                 s_axi_bvalid,      // write response valid
  input  logic                 s_axi_bready,      // write response ready
  output logic [1:0]           s_axi_bresp,       // write response
  input  logic                 s_axi_arvalid,     // read address valid
  output logic                 s_axi_arready,     // read address ready
  input  logic [ADDR_W-1:0]    s_axi_araddr,      // read byte address
  output logic                 s_axi_rvalid,      // read data valid
  input  logic                 s_axi_rready,      // read data ready
  output logic [31:0]          s_axi_rdata,       // read data
  output logic [1:0]           s_axi_rresp,       // read response
  input  logic [2:0]           pin_level,         // pin levels from the pads
  output gpa_pkg::gpa_pad_type pad_ctl,           // pad drive and pulls
  input  gpa_pkg::gpa_alt_type alt_func,          // peripheral outputs
  output logic [2:0]           ext_irq_in,        // pin levels to interrupt logic
  output logic                 external_clock_in, // clock taken from pin 2
  output logic                 irq                // level interrupt
);
  import gpa_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, IDX_LEVEL) || hit(a, IDX_DIR) || hit(a, IDX_CFG_LO) || hit(a, IDX_CFG_HI) ||
           hit(a, IDX_FSEL_LO) || hit(a, IDX_FSEL_HI) || hit(a, IDX_IRQ_STAT) || hit(a, IDX_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gpa_regs_type      regs_q, regs_d;
  gpa_pad_type       pad_d, pad_q;
  logic [2:0]        sync_lvl, prev_q, stat_q, stat_d, mask_q, mask_d, clr, evt, level_rb;
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic              awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic              arready_q, arready_d, rvalid_q, rvalid_d;
  logic              aw_take, w_take, wr_go, ar_take;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d, rd;
  logic [3:0]        wstrb_q, wstrb_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [2:0]        ext_q;
  logic              external_clock_in_q, irq_q, external_clock_in_d, irq_d;

  gpa_sync #(
    .WIDTH (NPIN)
  ) u_sync (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .pin_raw     (pin_level),
    .pin_settled (sync_lvl)
  );

  gpa_drive u_drive (
    .regs (regs_q),
    .alt  (alt_func),
    .pad  (pad_d)
  );

  // ----------------------------------------------------------------
  // bus channels
  // ----------------------------------------------------------------
  // address and data are held separately so either may come first
  always_comb begin
    aw_take   = s_axi_awvalid && awready_q;
    w_take    = s_axi_wvalid && wready_q;
    wr_go     = aw_full_q && w_full_q && !bvalid_q;
    aw_full_d = (aw_full_q || aw_take) && !wr_go;
    w_full_d  = (w_full_q || w_take) && !wr_go;
    awready_d = !aw_full_d;
    wready_d  = !w_full_d;
    awaddr_d  = aw_take ? s_axi_awaddr : awaddr_q;
    wdata_d   = w_take ? s_axi_wdata : wdata_q;
    wstrb_d   = w_take ? s_axi_wstrb : wstrb_q;
    bvalid_d  = wr_go || (bvalid_q && !s_axi_bready);
    bresp_d   = bresp_q;
    if (wr_go) begin
      bresp_d = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    ar_take   = s_axi_arvalid && arready_q;
    rvalid_d  = ar_take || (rvalid_q && !s_axi_rready);
    arready_d = !rvalid_d;
    rdata_d   = ar_take ? rd : rdata_q;
    rresp_d   = rresp_q;
    if (ar_take) begin
      rresp_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  assign level_rb = (regs_q.dir & sync_lvl) | (~regs_q.dir & regs_q.level);

  // bits not loaded stay zero, which covers the unused bits 7 to 3
  always_comb begin
    rd = '0;
    if (hit(s_axi_araddr, IDX_LEVEL)) begin
      rd[2:0] = level_rb;
    end else if (hit(s_axi_araddr, IDX_DIR)) begin
      rd[2:0] = regs_q.dir;
    end else if (hit(s_axi_araddr, IDX_CFG_LO)) begin
      rd[10:0] = {regs_q.cfg_hi, 5'h00, regs_q.cfg_lo};
    end else if (hit(s_axi_araddr, IDX_CFG_HI)) begin
      rd[2:0] = regs_q.cfg_hi;
    end else if (hit(s_axi_araddr, IDX_FSEL_LO)) begin
      rd[10:0] = {regs_q.fsel_hi, 5'h00, regs_q.fsel_lo};
    end else if (hit(s_axi_araddr, IDX_FSEL_HI)) begin
      rd[2:0] = regs_q.fsel_hi;
    end else if (hit(s_axi_araddr, IDX_IRQ_STAT)) begin
      rd[2:0] = stat_q;
    end else if (hit(s_axi_araddr, IDX_IRQ_MASK)) begin
      rd[2:0] = mask_q;
    end
  end

  // ----------------------------------------------------------------
  // register writes and pin-change status
  // ----------------------------------------------------------------
  assign evt = sync_lvl ^ prev_q;

  always_comb begin
    regs_d = regs_q;
    mask_d = mask_q;
    clr    = RST_PORT;
    if (wr_go && wstrb_q[0]) begin
      if (hit(awaddr_q, IDX_LEVEL)) begin
        regs_d.level = wdata_q[2:0];
      end else if (hit(awaddr_q, IDX_DIR)) begin
        regs_d.dir = wdata_q[2:0];
      end else if (hit(awaddr_q, IDX_CFG_LO)) begin
        regs_d.cfg_lo = wdata_q[2:0];
      end else if (hit(awaddr_q, IDX_CFG_HI)) begin
        regs_d.cfg_hi = wdata_q[2:0];
      end else if (hit(awaddr_q, IDX_FSEL_LO)) begin
        regs_d.fsel_lo = wdata_q[2:0];
      end else if (hit(awaddr_q, IDX_FSEL_HI)) begin
        regs_d.fsel_hi = wdata_q[2:0];
      end else if (hit(awaddr_q, IDX_IRQ_STAT)) begin
        clr = wdata_q[2:0];
      end else if (hit(awaddr_q, IDX_IRQ_MASK)) begin
        mask_d = wdata_q[2:0];
      end
    end
    if (wr_go && wstrb_q[1]) begin
      if (hit(awaddr_q, IDX_CFG_LO)) begin
        regs_d.cfg_hi = wdata_q[PAIR_LSB+:3];
      end else if (hit(awaddr_q, IDX_FSEL_LO)) begin
        regs_d.fsel_hi = wdata_q[PAIR_LSB+:3];
      end
    end
    // a new edge wins over a clear in the same cycle
    stat_d = (stat_q & ~clr) | evt;
    irq_d   = |(stat_q & mask_q);
    external_clock_in_d = sync_lvl[2] && ({regs_q.fsel_hi[2], regs_q.fsel_lo[2]} == FSEL_TER);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regs_q    <= RST_REGS;
      pad_q     <= RST_PAD;
      prev_q    <= RST_PORT;
      stat_q    <= RST_PORT;
      mask_q    <= RST_PORT;
      ext_q     <= RST_PORT;
      external_clock_in_q   <= 1'b0;
      irq_q     <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      rdata_q   <= '0;
      bresp_q   <= RESP_OKAY;
      rresp_q   <= RESP_OKAY;
    end else begin
      regs_q    <= regs_d;
      pad_q     <= pad_d;
      prev_q    <= sync_lvl;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      ext_q     <= sync_lvl;
      external_clock_in_q   <= external_clock_in_d;
      irq_q     <= irq_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      rdata_q   <= rdata_d;
      bresp_q   <= bresp_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;
  assign pad_ctl           = pad_q;
  assign ext_irq_in        = ext_q;
  assign external_clock_in = external_clock_in_q;
  assign irq               = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [2:0] hiz_out, pu_want, wr_hi;
  assign hiz_out = ~regs_q.dir & ~regs_q.cfg_hi & ~regs_q.cfg_lo;
  assign pu_want = regs_q.dir & regs_q.cfg_hi & ~regs_q.cfg_lo;
  assign wr_hi   = wdata_q[PAIR_LSB+:3];

  property p_reset_zero;
    @(posedge core_clk) $fell(sys_rst) |-> regs_q == RST_REGS && pad_q.oe == 3'h0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("port not hiz output after reset");

  property p_hiz_out;
    @(posedge core_clk) disable iff (sys_rst) ##1 (pad_q.oe & $past(hiz_out)) == 3'h0;
  endproperty
  a_hiz_out: assert property (p_hiz_out) else $error("hiz output pin is driven");

  property p_cmos_data;
    @(posedge core_clk) disable iff (sys_rst)
      regs_q.dir[0] == DIR_OUT && regs_q.cfg_hi[0] && regs_q.cfg_lo[0] && !regs_q.fsel_hi[0] && !regs_q.fsel_lo[0]
      |=> pad_q.oe[0] && pad_q.out[0] == $past(regs_q.level[0]);
  endproperty
  a_cmos_data: assert property (p_cmos_data) else $error("cmos pin does not follow data bit");

  property p_pull_up;
    @(posedge core_clk) disable iff (sys_rst) ##1 pad_q.pull_up == $past(pu_want);
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up not per input setting");

  property p_readback;
    @(posedge core_clk) disable iff (sys_rst)
      ar_take && hit(s_axi_araddr, IDX_LEVEL) |=> s_axi_rvalid && s_axi_rdata[2:0] == $past(level_rb);
  endproperty
  a_readback: assert property (p_readback) else $error("level readback wrong");

  property p_reserved;
    @(posedge core_clk) disable iff (sys_rst) s_axi_rvalid |-> s_axi_rdata[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("unused bits read nonzero");

  property p_half_word;
    @(posedge core_clk) disable iff (sys_rst)
      wr_go && wstrb_q[1] && hit(awaddr_q, IDX_CFG_LO) |=> regs_q.cfg_hi == $past(wr_hi);
  endproperty
  a_half_word: assert property (p_half_word) else $error("paired byte not written");

  property p_forbid;
    @(posedge core_clk) disable iff (sys_rst)
      regs_q.dir[1] == DIR_OUT && !regs_q.fsel_hi[1] && regs_q.fsel_lo[1] && regs_q.cfg_hi[1]
      |=> pad_q.oe[1] && !pad_q.out[1];
  endproperty
  a_forbid: assert property (p_forbid) else $error("prohibited pin not held low");

  property p_pwm;
    @(posedge core_clk) disable iff (sys_rst)
      regs_q.dir[0] == DIR_OUT && regs_q.cfg_hi[0] && regs_q.cfg_lo[0] && !regs_q.fsel_hi[0] && regs_q.fsel_lo[0]
      |=> pad_q.out[0] == $past(alt_func.pwm);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pin 0 not carrying pwm");

  property p_ext_irq;
    @(posedge core_clk) disable iff (sys_rst) $changed(sync_lvl) |=> ##[0:1] ext_irq_in == sync_lvl;
  endproperty
  a_ext_irq: assert property (p_ext_irq) else $error("interrupt input lost pin level");

  c_write_cfg: cover property (@(posedge core_clk) disable iff (sys_rst) wr_go && hit(awaddr_q, IDX_CFG_LO));
  c_read_lvl:  cover property (@(posedge core_clk) disable iff (sys_rst) ar_take && hit(s_axi_araddr, IDX_LEVEL));
  c_irq_rise:  cover property (@(posedge core_clk) disable iff (sys_rst) $rose(irq_q));
endmodule

/* src/gpa_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module gpa_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  logic             core_clk, // system clock
  input  logic             sys_rst,  // synchronous reset, active high
  input  logic [WIDTH-1:0] pin_raw,     // asynchronous pin levels
  output logic [WIDTH-1:0] pin_settled  // settled levels
);
  import gpa_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] lvl_d;

  // a level only counts once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign pin_settled = lvl_q;
endmodule
